// >>> core/pls_cfg.svh
// Constants for the PID loop supervisor: register offsets, fields, resets, timing
`ifndef PLS_CFG_SVH
`define PLS_CFG_SVH
// Register byte offsets on the AXI4-Lite slave
`define PLS_OFF_CTRL 8'h00
`define PLS_OFF_HIGH_BOUND 8'h04
`define PLS_OFF_LOW_BOUND 8'h08
`define PLS_OFF_HIGH_DELAY 8'h0c
`define PLS_OFF_LOW_DELAY 8'h10
`define PLS_OFF_HYST 8'h14
`define PLS_OFF_UPPER_CLAMP 8'h18
`define PLS_OFF_LOWER_CLAMP 8'h1c
`define PLS_OFF_AW_BAND 8'h20
`define PLS_OFF_LF_STOP 8'h24
`define PLS_OFF_LF_LATENCY 8'h28
`define PLS_OFF_LF_START 8'h2c
`define PLS_OFF_FREQ_LIMITS 8'h30
`define PLS_OFF_STATUS 8'h34
`define PLS_OFF_CLAMPED 8'h38
// Control register fields
`define PLS_CTRL_MODE_LSB 0
`define PLS_CTRL_MODE_MSB 3
`define PLS_CTRL_CLEAR_BIT 8
// Status register fields
`define PLS_ST_FLAG_BIT 0
`define PLS_ST_HIGH_BIT 1
`define PLS_ST_LOW_BIT 2
`define PLS_ST_FREEZE_BIT 3
`define PLS_ST_STOP_BIT 4
`define PLS_ST_ARMED_BIT 5
// Reset values
`define PLS_RST_MODE 4'h0
`define PLS_RST_UPPER_CLAMP 16'h03e7
`define PLS_RST_LOWER_CLAMP 16'h03e7
`define PLS_CLAMP_USE_GENERAL 16'h03e7
// Delay tick: delays count in steps of 10 ms
`define PLS_CLK_HZ 10000000
`define PLS_TICK_MS 10
`define PLS_TICK_CYCLES ((`PLS_CLK_HZ / 1000) * `PLS_TICK_MS)
`endif

// >>> core/pls_pkg.sv
// Types shared by the PID loop supervisor
`default_nettype none
package pls_pkg;
  typedef enum logic [2:0] {
    PLS_LF_RUN = 3'b001,
    PLS_LF_QUAL = 3'b010,
    PLS_LF_STOPPED = 3'b100
  } pls_lf_state_t;
  typedef struct packed {
    logic flag;
    logic high_alarm;
    logic low_alarm;
    logic freeze;
    logic lf_stopped;
  } pls_status_t;
endpackage
`default_nettype wire

// >>> core/pls_supervisor.sv
// PID loop supervisor: alarms, output clamp, anti-windup and low-flow stop
//
// Contract
// R01 - Modes 1-4: flag while feedback below low bound or above high bound.
// R02 - Modes 5-8: flag outside setpoint minus/plus bound magnitudes.
// R03 - Hold modes: flag stays off after power-on until region is left and re-entered.
// R04 - Latch modes: flag stays on once set, even after feedback leaves region.
// R05 - Latched flag is cleared only by the reset action, like alarm reset.
// R06 - High alarm after feedback above high bound longer than delay; zero disables.
// R07 - Low alarm after feedback below low bound longer than delay; zero disables.
// R08 - Delayed high and low alarms are evaluated only while running under PID.
// R09 - Bound alarms return to normal only past bound by hysteresis amount.
// R10 - Output clamp applies only to regulator output, not when PID is cancelled.
// R11 - Upper clamp in 0.1 Hz steps; 999 selects the general high limit.
// R12 - Lower clamp in 0.1 Hz steps; 999 selects the general low limit.
// R13 - Freeze integrator while deviation lies outside the anti-windup band.
// R14 - Band ranges 0.01 to 999 display units; zero disables the freeze.
// R15 - Freeze acts only on the first regulator channel.
// R16 - Output below stop level past latency: decelerate to stop, PID keeps running.
// R17 - After low-flow stop, resume once output rises above the start level.
// R18 - Low-flow stopped indicator is high exactly while stopped by low-flow.
// R19 - If start level below stop level, trigger stop below the start level instead.
// R20 - Delay counters count ticks while condition holds, restart when it lapses.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`include "pls_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pls_supervisor (
  input wire logic SYS_CLK,
  input wire logic NRST,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Process signals; feedback and setpoint in signed display units
  input wire logic signed [15:0] MEASURED_FEEDBACK,
  input wire logic signed [15:0] SETPOINT_VALUE,
  input wire logic [15:0] PID_OUTPUT,
  input wire logic PID_ACTIVE,
  input wire logic FAULT_CLEAR,
  output logic [15:0] FREQ_REFERENCE,
  output logic INTEGRATOR_FREEZE,
  output logic MOTOR_RUN_ENABLE,
  output logic SUPERVISION_FLAG,
  output logic HIGH_FEEDBACK_ALARM,
  output logic LOW_FEEDBACK_ALARM,
  output logic LOWFLOW_STOPPED_INDICATOR
);

  // ****************************************************************
  // Reset synchroniser and tick divider
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_n;
  logic [16:0] tick_cnt_reg;
  logic tick;

  // Two-stage release so the design leaves reset cleanly on a clock edge
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Divider giving one pulse per delay tick; 17 bits since a tick spans more than 65536 cycles
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 17'h00000;
    end else if (tick) begin
      tick_cnt_reg <= 17'h00000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 17'h00001;
    end
  end
  assign tick = (tick_cnt_reg == 17'(`PLS_TICK_CYCLES - 1));

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [3:0] mode_reg;
  logic signed [15:0] high_bound_reg, low_bound_reg, hyst_reg, aw_band_reg;
  logic [15:0] high_delay_reg, low_delay_reg, lf_latency_reg;
  logic [15:0] upper_clamp_reg, lower_clamp_reg, lf_stop_reg, lf_start_reg;
  logic [15:0] gen_high_reg, gen_low_reg;
  logic clear_pulse;
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic do_write;
  logic [31:0] rdata_next;
  logic rd_ok;
  pls_pkg::pls_status_t status;
  logic flag_armed_reg;

  // Merge 16-bit field with byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Address and data are taken in either order and held until both arrive
  assign S_AXI_AWREADY = !aw_hold_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_hold_reg && !S_AXI_BVALID;
  assign do_write = aw_hold_reg && w_hold_reg;
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      S_AXI_BVALID <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  assign S_AXI_BRESP = 2'b00;

  // Write strobes are captured with the data so a late address still sees them
  logic [3:0] w_strb_reg;
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      w_strb_reg <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_strb_reg <= S_AXI_WSTRB;
    end
  end

  // Setting registers; unmapped writes are accepted and dropped
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `PLS_RST_MODE;
      high_bound_reg <= 16'h0000;
      low_bound_reg <= 16'h0000;
      high_delay_reg <= 16'h0000;
      low_delay_reg <= 16'h0000;
      hyst_reg <= 16'h0000;
      upper_clamp_reg <= `PLS_RST_UPPER_CLAMP;
      lower_clamp_reg <= `PLS_RST_LOWER_CLAMP;
      aw_band_reg <= 16'h0000;
      lf_stop_reg <= 16'h0000;
      lf_latency_reg <= 16'h0000;
      lf_start_reg <= 16'h0000;
      gen_high_reg <= 16'hffff;
      gen_low_reg <= 16'h0000;
    end else if (do_write) begin
      case (aw_addr_reg)
        `PLS_OFF_CTRL: begin
          if (w_strb_reg[0]) begin
            mode_reg <= w_data_reg[`PLS_CTRL_MODE_MSB:`PLS_CTRL_MODE_LSB];
          end
        end
        `PLS_OFF_HIGH_BOUND: high_bound_reg <= merge16(high_bound_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_LOW_BOUND: low_bound_reg <= merge16(low_bound_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_HIGH_DELAY: high_delay_reg <= merge16(high_delay_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_LOW_DELAY: low_delay_reg <= merge16(low_delay_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_HYST: hyst_reg <= merge16(hyst_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_UPPER_CLAMP: upper_clamp_reg <= merge16(upper_clamp_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_LOWER_CLAMP: lower_clamp_reg <= merge16(lower_clamp_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_AW_BAND: aw_band_reg <= merge16(aw_band_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_LF_STOP: lf_stop_reg <= merge16(lf_stop_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_LF_LATENCY: lf_latency_reg <= merge16(lf_latency_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_LF_START: lf_start_reg <= merge16(lf_start_reg, w_data_reg, w_strb_reg);
        `PLS_OFF_FREQ_LIMITS: begin
          gen_low_reg <= merge16(gen_low_reg, w_data_reg, w_strb_reg);
          gen_high_reg <= merge16(gen_high_reg, {16'h0000, w_data_reg[31:16]},
                                  {2'b00, w_strb_reg[3:2]});
        end
        default: ;
      endcase
    end
  end

  // Writing the clear bit acts as the general alarm reset
  assign clear_pulse = do_write && (aw_addr_reg == `PLS_OFF_CTRL) && w_strb_reg[1]
                       && w_data_reg[`PLS_CTRL_CLEAR_BIT];

  // Read mux; unmapped addresses answer SLVERR with zero data
  always_comb begin
    rd_ok = 1'b1;
    rdata_next = 32'h0000_0000;
    case (S_AXI_ARADDR)
      `PLS_OFF_CTRL: rdata_next = {28'h0000000, mode_reg};
      `PLS_OFF_HIGH_BOUND: rdata_next = {16'h0000, high_bound_reg};
      `PLS_OFF_LOW_BOUND: rdata_next = {16'h0000, low_bound_reg};
      `PLS_OFF_HIGH_DELAY: rdata_next = {16'h0000, high_delay_reg};
      `PLS_OFF_LOW_DELAY: rdata_next = {16'h0000, low_delay_reg};
      `PLS_OFF_HYST: rdata_next = {16'h0000, hyst_reg};
      `PLS_OFF_UPPER_CLAMP: rdata_next = {16'h0000, upper_clamp_reg};
      `PLS_OFF_LOWER_CLAMP: rdata_next = {16'h0000, lower_clamp_reg};
      `PLS_OFF_AW_BAND: rdata_next = {16'h0000, aw_band_reg};
      `PLS_OFF_LF_STOP: rdata_next = {16'h0000, lf_stop_reg};
      `PLS_OFF_LF_LATENCY: rdata_next = {16'h0000, lf_latency_reg};
      `PLS_OFF_LF_START: rdata_next = {16'h0000, lf_start_reg};
      `PLS_OFF_FREQ_LIMITS: rdata_next = {gen_high_reg, gen_low_reg};
      // Fields placed one by one so the flag lands in bit 0 as the map says
      `PLS_OFF_STATUS: rdata_next = {26'h0000000, flag_armed_reg, status.lf_stopped,
                                     status.freeze, status.low_alarm, status.high_alarm,
                                     status.flag};
      `PLS_OFF_CLAMPED: rdata_next = {16'h0000, FREQ_REFERENCE};
      default: rd_ok = 1'b0;
    endcase
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'b00;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rdata_next;
      S_AXI_RRESP <= rd_ok ? 2'b00 : 2'b10;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // Supervision flag
  // ****************************************************************
  function automatic logic signed [17:0] mag(input logic signed [15:0] v);
    mag = (v < 0) ? -18'(v) : 18'(v);
  endfunction

  logic signed [17:0] fb, sp, hb, lb;
  logic in_region, mode_dev, mode_hold, mode_latch, mode_on;
  logic flag_reg, prev_region_reg;
  assign fb = 18'(MEASURED_FEEDBACK);
  assign sp = 18'(SETPOINT_VALUE);
  assign hb = 18'(high_bound_reg);
  assign lb = 18'(low_bound_reg);
  assign mode_on = (mode_reg >= 4'h1) && (mode_reg <= 4'h8);
  assign mode_dev = (mode_reg >= 4'h5);
  assign mode_hold = (mode_reg == 4'h2) || (mode_reg == 4'h4) || (mode_reg == 4'h6)
                     || (mode_reg == 4'h8);
  assign mode_latch = (mode_reg == 4'h3) || (mode_reg == 4'h4) || (mode_reg == 4'h7)
                      || (mode_reg == 4'h8);
  assign in_region = mode_dev
      ? ((fb < sp - mag(low_bound_reg)) || (fb > sp + mag(high_bound_reg)))  // see R02
      : ((fb < lb) || (fb > hb));  // see R01

  // Arming: hold modes arm only after the region has been left once
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      flag_armed_reg <= 1'b0;
      prev_region_reg <= 1'b0;
    end else begin
      prev_region_reg <= in_region;
      if (!in_region) begin
        flag_armed_reg <= 1'b1;  // see R03
      end
    end
  end

  // Latched flag survives region exit; only the reset action drops it
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (mode_on && in_region && (flag_armed_reg || !mode_hold)) begin
      flag_reg <= 1'b1;  // see R01 see R02 see R03
    end else if (mode_latch && flag_reg && mode_on) begin
      if (clear_pulse || FAULT_CLEAR) begin
        flag_reg <= 1'b0;  // see R05
      end
    end else begin
      flag_reg <= 1'b0;  // see R04
    end
  end
  assign SUPERVISION_FLAG = flag_reg;

  // ****************************************************************
  // Delayed feedback alarms with hysteresis
  // ****************************************************************
  logic [15:0] hi_cnt_reg, lo_cnt_reg;
  logic hi_alarm_reg, lo_alarm_reg, hi_cond, lo_cond;
  assign hi_cond = PID_ACTIVE && (high_delay_reg != 16'h0000) && (fb > hb);  // see R06 see R08
  assign lo_cond = PID_ACTIVE && (low_delay_reg != 16'h0000) && (fb < lb);  // see R07 see R08

  // Counters restart whenever the condition lapses before expiry
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_reg <= 16'h0000;
      lo_cnt_reg <= 16'h0000;
    end else begin
      if (!hi_cond) hi_cnt_reg <= 16'h0000;  // see R20
      else if (tick && hi_cnt_reg != 16'hffff) hi_cnt_reg <= hi_cnt_reg + 16'h0001;
      if (!lo_cond) lo_cnt_reg <= 16'h0000;  // see R20
      else if (tick && lo_cnt_reg != 16'hffff) lo_cnt_reg <= lo_cnt_reg + 16'h0001;
    end
  end

  // Alarms drop once feedback is back past the bound by the hysteresis, or when PID stops or the delay is zero
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hi_alarm_reg <= 1'b0;
      lo_alarm_reg <= 1'b0;
    end else begin
      if (hi_cond && hi_cnt_reg > high_delay_reg) hi_alarm_reg <= 1'b1;  // see R06
      else if (!PID_ACTIVE || high_delay_reg == 16'h0000
               || fb <= hb - mag(hyst_reg)) hi_alarm_reg <= 1'b0;  // see R09
      if (lo_cond && lo_cnt_reg > low_delay_reg) lo_alarm_reg <= 1'b1;  // see R07
      else if (!PID_ACTIVE || low_delay_reg == 16'h0000
               || fb >= lb + mag(hyst_reg)) lo_alarm_reg <= 1'b0;  // see R09
    end
  end
  assign HIGH_FEEDBACK_ALARM = hi_alarm_reg;
  assign LOW_FEEDBACK_ALARM = lo_alarm_reg;

  // ****************************************************************
  // Output clamp and anti-windup
  // ****************************************************************
  logic [15:0] up_lim, lo_lim, freq_reg;
  logic freeze_reg;
  logic signed [17:0] dev;
  assign up_lim = (upper_clamp_reg == `PLS_CLAMP_USE_GENERAL) ? gen_high_reg
                  : upper_clamp_reg;  // see R11
  assign lo_lim = (lower_clamp_reg == `PLS_CLAMP_USE_GENERAL) ? gen_low_reg
                  : lower_clamp_reg;  // see R12
  assign dev = fb - sp;

  // Clamp only the regulator path; a cancelled loop passes the reference through
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      freq_reg <= 16'h0000;
    end else if (!PID_ACTIVE) begin
      freq_reg <= PID_OUTPUT;  // see R10
    end else if (PID_OUTPUT > up_lim) begin
      freq_reg <= up_lim;  // see R11
    end else if (PID_OUTPUT < lo_lim) begin
      freq_reg <= lo_lim;  // see R12
    end else begin
      freq_reg <= PID_OUTPUT;
    end
  end
  assign FREQ_REFERENCE = freq_reg;

  // Only this block's regulator has the freeze; a zero band turns it off
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      freeze_reg <= 1'b0;
    end else begin
      freeze_reg <= PID_ACTIVE && (aw_band_reg != 16'h0000)  // see R14 see R15
                    && (mag(16'(dev)) > mag(aw_band_reg) || dev > 18'sd32767
                        || dev < -18'sd32768);  // see R13
    end
  end
  assign INTEGRATOR_FREEZE = freeze_reg;

  // ****************************************************************
  // Low-flow stop
  // ****************************************************************
  pls_pkg::pls_lf_state_t lf_state_reg;
  logic [15:0] lf_cnt_reg, eff_stop;
  logic lf_low;
  assign eff_stop = (lf_start_reg < lf_stop_reg) ? lf_start_reg : lf_stop_reg;  // see R19
  assign lf_low = PID_ACTIVE && (PID_OUTPUT < eff_stop);

  // Sleep sequencer; the regulator keeps computing while the motor is stopped
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lf_state_reg <= pls_pkg::PLS_LF_RUN;
      lf_cnt_reg <= 16'h0000;
    end else begin
      case (lf_state_reg)
        pls_pkg::PLS_LF_RUN: begin
          lf_cnt_reg <= 16'h0000;
          if (lf_low) lf_state_reg <= pls_pkg::PLS_LF_QUAL;
        end
        pls_pkg::PLS_LF_QUAL: begin
          if (!lf_low) begin
            lf_state_reg <= pls_pkg::PLS_LF_RUN;  // see R20
          end else if (lf_cnt_reg >= lf_latency_reg) begin
            lf_state_reg <= pls_pkg::PLS_LF_STOPPED;  // see R16
          end else if (tick) begin
            lf_cnt_reg <= lf_cnt_reg + 16'h0001;
          end
        end
        pls_pkg::PLS_LF_STOPPED: begin
          if (!PID_ACTIVE || PID_OUTPUT > lf_start_reg) begin
            lf_state_reg <= pls_pkg::PLS_LF_RUN;  // see R17
          end
        end
        default: lf_state_reg <= pls_pkg::PLS_LF_RUN;
      endcase
    end
  end
  assign LOWFLOW_STOPPED_INDICATOR = (lf_state_reg == pls_pkg::PLS_LF_STOPPED);  // see R18
  assign MOTOR_RUN_ENABLE = !LOWFLOW_STOPPED_INDICATOR;  // see R16

  assign status = '{flag: flag_reg, high_alarm: hi_alarm_reg, low_alarm: lo_alarm_reg,
                    freeze: freeze_reg, lf_stopped: LOWFLOW_STOPPED_INDICATOR};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_latch_holds: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    mode_latch && mode_on && flag_reg && !clear_pulse && !FAULT_CLEAR && $stable(mode_reg)
    |=> flag_reg) else $error("latched flag dropped");  // see R04
  a_flag_abs: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    (mode_reg == 4'h1) && $stable(mode_reg) |=> flag_reg == $past(in_region))
    else $error("absolute flag wrong");  // see R01
  a_hold_blocks: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    mode_hold && !flag_armed_reg && !flag_reg |=> !flag_reg)
    else $error("hold flag raised early");  // see R03
  a_high_disabled: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    high_delay_reg == 16'h0000 |=> !hi_alarm_reg) else $error("high alarm disabled");  // see R06
  a_low_needs_pid: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    !PID_ACTIVE |=> !lo_alarm_reg && !hi_alarm_reg) else $error("alarm without pid");  // see R08
  a_clamp_bounds: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    PID_ACTIVE && $stable(up_lim) && up_lim >= lo_lim |=> freq_reg <= $past(up_lim))
    else $error("clamp exceeded");  // see R11
  a_freeze_off: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    aw_band_reg == 16'h0000 |=> !freeze_reg) else $error("freeze while disabled");  // see R14
  a_stop_indicator: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    $rose(LOWFLOW_STOPPED_INDICATOR) |-> $past(lf_low))
    else $error("stop indicator without low flow");  // see R18
  a_lf_resume: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    LOWFLOW_STOPPED_INDICATOR && PID_OUTPUT > lf_start_reg |=> MOTOR_RUN_ENABLE)
    else $error("no resume");  // see R17
  c_flag_set: cover property (@(posedge SYS_CLK) disable iff (!rst_n) $rose(flag_reg));
  c_high_alarm: cover property (@(posedge SYS_CLK) disable iff (!rst_n) $rose(hi_alarm_reg));
  c_lf_stop: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
    $rose(LOWFLOW_STOPPED_INDICATOR));
  c_freeze: cover property (@(posedge SYS_CLK) disable iff (!rst_n) $rose(freeze_reg));

endmodule // pls_supervisor
`default_nettype wire

// >>> test/pls_process_model.sv
// Process side model: feedback sensor, setpoint source and drive stage
`timescale 1ns/1ps
`default_nettype none
module pls_process_model (
  input wire logic clk,
  input wire logic signed [15:0] f_i,
  input wire logic signed [15:0] s_i,
  input wire logic [15:0] o_i,
  input wire logic p_i,
  input wire logic c_i,
  output logic signed [15:0] f,
  output logic signed [15:0] s,
  output logic [15:0] o,
  output logic p,
  output logic c
);
  // Levels settle one clock after the bench commands them, like a slow sensor
  always_ff @(posedge clk) begin
    f <= f_i;
    s <= s_i;
    o <= o_i;
    p <= p_i;
    c <= c_i;
  end
endmodule // pls_process_model
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the PID loop supervisor
`include "pls_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic SYS_CLK = 1'b0, NRST = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, p_w = 1'b0, c_w = 1'b0;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdat;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rrsp;
  logic signed [15:0] MEASURED_FEEDBACK, SETPOINT_VALUE, f_w = 16'sh0, s_w = 16'sh0;
  logic [15:0] PID_OUTPUT, FREQ_REFERENCE, o_w = 16'h0;
  logic PID_ACTIVE, FAULT_CLEAR, INTEGRATOR_FREEZE, MOTOR_RUN_ENABLE, SUPERVISION_FLAG;
  logic HIGH_FEEDBACK_ALARM, LOW_FEEDBACK_ALARM, LOWFLOW_STOPPED_INDICATOR;
  int num_errors = 0, checks_done = 0, cyc = 0;
  pls_supervisor dut (.*);
  pls_process_model model (.clk(SYS_CLK), .f_i(f_w), .s_i(s_w), .o_i(o_w), .p_i(p_w),
    .c_i(c_w), .f(MEASURED_FEEDBACK), .s(SETPOINT_VALUE), .o(PID_OUTPUT), .p(PID_ACTIVE),
    .c(FAULT_CLEAR));
  always #50 SYS_CLK = ~SYS_CLK;
  // Cut a hang short; the tests need about 160 cycles
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Handshakes are judged at the falling edge, where levels equal those at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    forever begin
      @(negedge SYS_CLK);
      ta = S_AXI_AWVALID & S_AXI_AWREADY;
      tw = S_AXI_WVALID & S_AXI_WREADY;
      tb = S_AXI_BVALID;
      @(posedge SYS_CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      if (tb) break;
    end
    S_AXI_BREADY <= 1'b0;
    // Let an edge pass so the next call does not raise bready in this same step
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    forever begin
      @(negedge SYS_CLK);
      ta = S_AXI_ARVALID & S_AXI_ARREADY;
      rdat = S_AXI_RDATA;
      rrsp = S_AXI_RRESP;
      if (S_AXI_RVALID) break;
      @(posedge SYS_CLK);
      if (ta) S_AXI_ARVALID <= 1'b0;
    end
    @(posedge SYS_CLK);
    S_AXI_RREADY <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic st(input logic signed [15:0] f, s, input logic [15:0] o, input logic p);
    f_w <= f;
    s_w <= s;
    o_w <= o;
    p_w <= p;
    repeat (5) @(posedge SYS_CLK);
  endtask
  task automatic t_regs;
    rd(`PLS_OFF_UPPER_CLAMP);
    chk("upper clamp", 32'h3e7, rdat);
    rd(8'h3c);
    chk("unmapped resp", 32'h2, {30'h0, rrsp});
    $display("regs done");
  endtask
  task automatic t_abs;
    wr(`PLS_OFF_HIGH_BOUND, 32'h64);
    wr(`PLS_OFF_LOW_BOUND, 32'hff9c);
    wr(`PLS_OFF_HIGH_DELAY, 32'h0);
    wr(`PLS_OFF_CTRL, 32'h1);
    st(200, 0, 0, 1);
    chk("flag", 1, SUPERVISION_FLAG);
    chk("high alarm", 0, HIGH_FEEDBACK_ALARM);
    st(0, 0, 0, 1);
    chk("flag", 0, SUPERVISION_FLAG);
    st(-200, 0, 0, 1);
    chk("flag", 1, SUPERVISION_FLAG);
    chk("low alarm", 0, LOW_FEEDBACK_ALARM);
    wr(`PLS_OFF_CTRL, 32'h3);
    st(200, 0, 0, 1);
    st(0, 0, 0, 1);
    chk("latched flag", 1, SUPERVISION_FLAG);
    c_w <= 1'b1;
    @(posedge SYS_CLK);
    c_w <= 1'b0;
    st(0, 0, 0, 1);
    chk("cleared flag", 0, SUPERVISION_FLAG);
    wr(`PLS_OFF_CTRL, 32'h5);
    st(1050, 1000, 0, 1);
    chk("dev flag", 0, SUPERVISION_FLAG);
    st(850, 1000, 0, 1);
    chk("dev flag", 1, SUPERVISION_FLAG);
    $display("alarm done");
  endtask
  task automatic t_out;
    wr(`PLS_OFF_UPPER_CLAMP, 32'h1f4);
    wr(`PLS_OFF_LOWER_CLAMP, 32'h64);
    wr(`PLS_OFF_AW_BAND, 32'h32);
    st(1100, 1000, 800, 1);
    chk("freq ref", 500, FREQ_REFERENCE);
    chk("freeze", 1, INTEGRATOR_FREEZE);
    st(1020, 1000, 50, 1);
    chk("freq ref", 100, FREQ_REFERENCE);
    chk("freeze", 0, INTEGRATOR_FREEZE);
    st(0, 0, 50, 0);
    chk("freq ref", 50, FREQ_REFERENCE);
    wr(`PLS_OFF_LF_STOP, 32'hc8);
    wr(`PLS_OFF_LF_LATENCY, 32'h0);
    wr(`PLS_OFF_LF_START, 32'hfa);
    st(0, 0, 150, 1);
    chk("stopped", 1, LOWFLOW_STOPPED_INDICATOR);
    chk("run", 0, MOTOR_RUN_ENABLE);
    st(0, 0, 300, 1);
    chk("stopped", 0, LOWFLOW_STOPPED_INDICATOR);
    chk("run", 1, MOTOR_RUN_ENABLE);
    $display("output done");
  endtask
  // Reset in mid-run with feedback already in the region, then a hold mode
  task automatic t_hold;
    f_w <= 16'sd200;
    NRST <= 1'b0;
    repeat (5) @(posedge SYS_CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    wr(`PLS_OFF_CTRL, 32'h2);
    st(200, 0, 0, 1);
    chk("hold flag", 0, SUPERVISION_FLAG);
    st(0, 0, 0, 1);
    st(200, 0, 0, 1);
    chk("armed flag", 1, SUPERVISION_FLAG);
    rd(`PLS_OFF_STATUS);
    chk("status", 32'h21, rdat);
    $display("hold done");
  endtask
  initial begin
    repeat (5) @(posedge SYS_CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    t_regs();
    t_abs();
    t_out();
    t_hold();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
